// ### hdl/ee_link_params.svh
`ifndef EE_LINK_PARAMS_SVH
`define EE_LINK_PARAMS_SVH
// ****************************************
// instruction codes
// ****************************************
`define CMD_SET_LATCH 8'h06
`define CMD_CLR_LATCH 8'h04
`define CMD_STAT_RD 8'h05
`define CMD_STAT_WR 8'h01
`define CMD_MEM_RD 3'h3
`define CMD_MEM_WR 3'h2
`define CMD_PAGE_BIT 3
// ****************************************
// status byte
// ****************************************
`define SR_BUSY 0
`define SR_LATCH 1
`define SR_BP_LO 2
`define SR_BP_HI 3
`define SR_RO_VALUE 4'h0
`define BURST_MAX 16
// ****************************************
// timing
// ****************************************
`define CLK_PERIOD_NS 8
`define WRITE_TIME_NS 5000
`define WRITE_CYCLES ((`WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define HALF_RATE0 8'h08
`define HALF_RATE1 8'h10
`define HALF_RATE2 8'h20
`define HALF_RATE3 8'h80
// ****************************************
// controller register map
// ****************************************
`define REG_CTRL 8'h00
`define REG_DATA 8'h04
`define REG_STAT 8'h08
`define CTRL_RATE_LO 0
`define CTRL_RATE_HI 1
`define CTRL_MODE 2
`define CTRL_OE 3
`define CTRL_FRAME 4
`define CTRL_DEV 5
`define STAT_BUSY 0
`define STAT_RX 8
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### hdl/ee_link_pkg.sv
package ee_link_pkg;
  typedef enum logic [2:0] {
    PH_CMD = 3'b000,
    PH_ADDR = 3'b001,
    PH_WDATA = 3'b010,
    PH_SRW = 3'b011,
    PH_STATUS_READ_CMD = 3'b100,
    PH_RDMEM = 3'b101,
    PH_IGNORE = 3'b110
  } phase_t;
  typedef enum logic [2:0] {
    PEND_NONE = 3'b000,
    PEND_SET = 3'b001,
    PEND_CLR = 3'b010,
    PEND_SR = 3'b011,
    PEND_WR = 3'b100
  } pend_t;
  typedef struct packed {
    phase_t phase;
    pend_t pend;
    logic rd;
    logic page;
    logic [7:0] addr;
    logic [2:0] bit_cnt;
    logic [7:0] shin;
    logic [7:0] shout;
    logic miso_oe;
    logic sclk;
    logic cs;
    logic [4:0] buf_cnt;
    logic [4:0] commit;
    logic [1:0] sr_new;
    logic [1:0] bp;
    logic write_latch_flag;
    logic busy;
    logic [19:0] wcnt;
    logic [7:0] status;
  } dev_state_t;
  typedef struct packed {
    logic [6:0] ctrl;
    logic [7:0] tx;
    logic [7:0] rx;
    logic busy;
    logic sclk;
    logic [3:0] cs_n;
    logic [4:0] edge_cnt;
    logic [7:0] div_cnt;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [7:0] wdata;
    logic wstrb0;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } host_state_t;
endpackage

// ### hdl/ee_link_if.sv
`timescale 1ns/1ps
interface ee_link_if #(parameter int NSEL = 2);
  logic sclk;
  logic mosi;
  logic [NSEL-1:0] cs_n;
  logic miso_o;
  logic miso_oe;
  logic miso;
  // undriven line floats high through the pull-up
  assign miso = miso_oe ? miso_o : 1'b1;
  modport host_mp (output sclk, output mosi, output cs_n, input miso);
  modport dev_mp (input sclk, input mosi, input cs_n, output miso_o, output miso_oe);
endinterface

// ### hdl/ee_sync.sv
`timescale 1ns/1ps
module ee_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // levels
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= INIT;
      q <= INIT;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule

// ### hdl/ee_device.sv
`timescale 1ns/1ps
`include "ee_link_params.svh"
module ee_device #(
  parameter int SEL_INDEX = 0,
  parameter int WRITE_CYCLES = `WRITE_CYCLES
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  ee_link_if.dev_mp link,
  // user side
  output logic [7:0] status_q
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [7:0] status_byte(logic [1:0] bp, logic write_latch_flag, logic busy);
    status_byte = {`SR_RO_VALUE, bp, write_latch_flag, busy};
  endfunction

  // upper quarter, upper half or whole array; sixteen-byte pages never straddle
  function automatic logic is_protected(logic [1:0] bp, logic page, logic [7:0] addr);
    case (bp)
      2'h0: is_protected = 1'b0;
      2'h1: is_protected = page & addr[7];
      2'h2: is_protected = page;
      default: is_protected = 1'b1;
    endcase
  endfunction

  // ****************************************
  // pin sampling
  // ****************************************
  logic [2:0] pins_s;
  ee_sync #(.W(3), .INIT(3'h4)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d({link.cs_n[SEL_INDEX], link.sclk, link.mosi}),
    .q(pins_s)
  );

  logic [7:0] mem [0:511];
  logic [7:0] wbuf [0:`BURST_MAX-1];
  ee_link_pkg::dev_state_t s_q, s_d;
  logic mem_we, buf_we;
  logic [8:0] mem_wa;
  logic [3:0] buf_wa;
  logic [7:0] buf_wd;
  logic [7:0] rd_byte;
  logic [7:0] b;
  logic rise, fall;

  // ****************************************
  // protocol engine
  // ****************************************
  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_wa = {s_q.page, s_q.addr[7:4], s_q.addr[3:0] + s_q.commit[3:0]};
    buf_we = 1'b0;
    buf_wa = s_q.buf_cnt[3:0];
    b = {s_q.shin[6:0], pins_s[0]};
    buf_wd = b;
    rise = pins_s[1] & ~s_q.sclk;
    fall = ~pins_s[1] & s_q.sclk;
    rd_byte = mem[{s_q.page, s_q.addr}];
    s_d.sclk = pins_s[1];
    s_d.cs = pins_s[2];
    if (pins_s[2]) begin
      s_d.phase = ee_link_pkg::PH_CMD;
      s_d.bit_cnt = 3'h0;
      s_d.miso_oe = 1'b0;
      s_d.pend = ee_link_pkg::PEND_NONE;
      if (!s_q.cs && s_q.bit_cnt == 3'h0 && !s_q.busy) begin
        case (s_q.pend)
          ee_link_pkg::PEND_SET: s_d.write_latch_flag = 1'b1;
          ee_link_pkg::PEND_CLR: s_d.write_latch_flag = 1'b0;
          ee_link_pkg::PEND_SR: begin
            if (s_q.write_latch_flag) begin
              s_d.bp = s_q.sr_new;
              s_d.write_latch_flag = 1'b0;
            end
          end
          ee_link_pkg::PEND_WR: begin
            if (s_q.write_latch_flag && s_q.buf_cnt != 5'h0 &&
                !is_protected(s_q.bp, s_q.page, s_q.addr)) begin
              s_d.busy = 1'b1;
              s_d.wcnt = 20'(WRITE_CYCLES - 1);
              s_d.commit = 5'h0;
              s_d.write_latch_flag = 1'b0;
            end
          end
          default: s_d.pend = ee_link_pkg::PEND_NONE;
        endcase
      end
    end else begin
      if (rise) begin
        s_d.shin = b;
        s_d.bit_cnt = s_q.bit_cnt + 3'h1;
        if (s_q.bit_cnt == 3'h7) begin
          case (s_q.phase)
            ee_link_pkg::PH_CMD: begin
              s_d.phase = ee_link_pkg::PH_IGNORE;
              if (b == `CMD_STAT_RD) begin
                s_d.phase = ee_link_pkg::PH_STATUS_READ_CMD;
                s_d.shout = status_byte(s_q.bp, s_q.write_latch_flag, s_q.busy);
                s_d.miso_oe = 1'b1;
              end else if (s_q.busy) begin
                s_d.phase = ee_link_pkg::PH_IGNORE;
              end else if (b == `CMD_SET_LATCH) begin
                s_d.pend = ee_link_pkg::PEND_SET;
              end else if (b == `CMD_CLR_LATCH) begin
                s_d.pend = ee_link_pkg::PEND_CLR;
              end else if (b == `CMD_STAT_WR) begin
                s_d.phase = ee_link_pkg::PH_SRW;
              end else if (b[7:4] == 4'h0 && b[2:0] == `CMD_MEM_RD) begin
                s_d.phase = ee_link_pkg::PH_ADDR;
                s_d.rd = 1'b1;
                s_d.page = b[`CMD_PAGE_BIT];
              end else if (b[7:4] == 4'h0 && b[2:0] == `CMD_MEM_WR) begin
                s_d.phase = ee_link_pkg::PH_ADDR;
                s_d.rd = 1'b0;
                s_d.page = b[`CMD_PAGE_BIT];
              end
            end
            ee_link_pkg::PH_ADDR: begin
              s_d.addr = b;
              s_d.buf_cnt = 5'h0;
              if (s_q.rd) begin
                s_d.phase = ee_link_pkg::PH_RDMEM;
                s_d.shout = mem[{s_q.page, b}];
                s_d.miso_oe = 1'b1;
                s_d.addr = b + 8'h01;
              end else begin
                s_d.phase = ee_link_pkg::PH_WDATA;
              end
            end
            ee_link_pkg::PH_WDATA: begin
              s_d.pend = ee_link_pkg::PEND_WR;
              if (s_q.buf_cnt != 5'(`BURST_MAX)) begin
                buf_we = 1'b1;
                s_d.buf_cnt = s_q.buf_cnt + 5'h01;
              end
            end
            ee_link_pkg::PH_SRW: begin
              s_d.sr_new = b[`SR_BP_HI:`SR_BP_LO];
              s_d.pend = ee_link_pkg::PEND_SR;
              s_d.phase = ee_link_pkg::PH_IGNORE;
            end
            ee_link_pkg::PH_STATUS_READ_CMD: s_d.shout = status_byte(s_q.bp, s_q.write_latch_flag, s_q.busy);
            ee_link_pkg::PH_RDMEM: begin
              s_d.shout = rd_byte;
              s_d.addr = s_q.addr + 8'h01;
            end
            default: s_d.phase = ee_link_pkg::PH_IGNORE;
          endcase
        end
      end
      // the first edge of a byte in mode (1,1) falls before any capture
      if (fall && s_q.bit_cnt != 3'h0) begin
        s_d.shout = {s_q.shout[6:0], 1'b0};
      end
    end
    if (s_q.busy) begin
      if (s_q.commit != s_q.buf_cnt) begin
        mem_we = 1'b1;
        s_d.commit = s_q.commit + 5'h01;
      end
      s_d.wcnt = s_q.wcnt - 20'h1;
      if (s_q.wcnt == 20'h0) begin
        s_d.busy = 1'b0;
      end
    end
    s_d.status = status_byte(s_d.bp, s_d.write_latch_flag, s_d.busy);
  end

  // ****************************************
  // state and storage
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.phase <= ee_link_pkg::PH_CMD;
      s_q.pend <= ee_link_pkg::PEND_NONE;
      s_q.cs <= 1'b1;
      s_q.status <= {`SR_RO_VALUE, 4'h0};
    end else begin
      s_q <= s_d;
    end
  end

  // contents are not reset: a real array keeps them
  always_ff @(posedge aclk) begin
    if (mem_we) begin
      mem[mem_wa] <= wbuf[s_q.commit[3:0]];
    end
    if (buf_we) begin
      wbuf[buf_wa] <= buf_wd;
    end
  end

  assign link.miso_o = s_q.shout[7];
  assign link.miso_oe = s_q.miso_oe;
  assign status_q = s_q.status;
endmodule

// ### hdl/ee_host.sv
`timescale 1ns/1ps
`include "ee_link_params.svh"
module ee_host #(
  parameter int NSEL = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  ee_link_if.host_mp link,
  // write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [7:0] s_axi_awaddr,
  // write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [7:0] s_axi_araddr,
  // read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp
);
  // ****************************************
  // helpers
  // ****************************************
  // rates are slower than the cpu ratios: the far end samples through two flops
  function automatic logic [7:0] half_period(logic [1:0] sel);
    case (sel)
      2'h0: half_period = `HALF_RATE0;
      2'h1: half_period = `HALF_RATE1;
      2'h2: half_period = `HALF_RATE2;
      default: half_period = `HALF_RATE3;
    endcase
  endfunction

  logic miso_s;
  ee_sync #(.W(1), .INIT(1'b1)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(link.miso),
    .q(miso_s)
  );

  ee_link_pkg::host_state_t s_q, s_d;
  logic mode;
  logic [1:0] dev;

  // ****************************************
  // bus slave and shifter
  // ****************************************
  always_comb begin
    s_d = s_q;
    mode = s_q.ctrl[`CTRL_MODE];
    dev = s_q.ctrl[`CTRL_DEV+1:`CTRL_DEV];
    if (s_axi_awvalid && s_q.awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = s_axi_awaddr;
      s_d.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.wready) begin
      s_d.w_got = 1'b1;
      s_d.wdata = s_axi_wdata[7:0];
      s_d.wstrb0 = s_axi_wstrb[0];
      s_d.wready = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `RESP_OKAY;
      case (s_q.aw_addr)
        `REG_CTRL: begin
          if (s_q.wstrb0) begin
            s_d.ctrl = s_q.wdata[6:0];
          end
        end
        `REG_DATA: begin
          // refused while a byte is moving or the output is off
          if (s_q.wstrb0 && !s_q.busy && s_q.ctrl[`CTRL_OE]) begin
            s_d.tx = s_q.wdata;
            s_d.busy = 1'b1;
            s_d.edge_cnt = 5'h0;
            s_d.div_cnt = 8'h0;
          end
        end
        `REG_STAT: s_d.bresp = `RESP_OKAY;
        default: s_d.bresp = `RESP_SLVERR;
      endcase
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end
    if (s_axi_arvalid && s_q.arready) begin
      s_d.arready = 1'b0;
      s_d.rvalid = 1'b1;
      s_d.rresp = `RESP_OKAY;
      s_d.rdata = 32'h0;
      case (s_axi_araddr)
        `REG_CTRL: s_d.rdata = {25'h0, s_q.ctrl};
        `REG_STAT: s_d.rdata = {16'h0, s_q.rx, 7'h0, s_q.busy};
        `REG_DATA: s_d.rdata = {24'h0, s_q.tx};
        default: s_d.rresp = `RESP_SLVERR;
      endcase
    end
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end
    if (s_q.busy) begin
      s_d.div_cnt = s_q.div_cnt + 8'h01;
      if (s_q.div_cnt == half_period(s_q.ctrl[`CTRL_RATE_HI:`CTRL_RATE_LO]) - 8'h01) begin
        s_d.div_cnt = 8'h0;
        s_d.sclk = ~s_q.sclk;
        s_d.edge_cnt = s_q.edge_cnt + 5'h01;
        if (!s_q.sclk) begin
          s_d.rx = {s_q.rx[6:0], miso_s};
        end else if (s_q.edge_cnt != 5'h0) begin
          s_d.tx = {s_q.tx[6:0], 1'b0};
        end
        if (s_q.edge_cnt == 5'h0f) begin
          s_d.busy = 1'b0;
        end
      end
    end else begin
      s_d.sclk = mode;
    end
    s_d.cs_n = 4'hf;
    if (s_q.ctrl[`CTRL_OE] && s_q.ctrl[`CTRL_FRAME] && 32'(dev) < NSEL) begin
      s_d.cs_n[dev] = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q <= '0;
      s_q.cs_n <= 4'hf;
      s_q.awready <= 1'b1;
      s_q.wready <= 1'b1;
      s_q.arready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.sclk = s_q.sclk;
  assign link.mosi = s_q.tx[7];
  assign link.cs_n = s_q.cs_n[NSEL-1:0];
  assign s_axi_awready = s_q.awready;
  assign s_axi_wready = s_q.wready;
  assign s_axi_bvalid = s_q.bvalid;
  assign s_axi_bresp = s_q.bresp;
  assign s_axi_arready = s_q.arready;
  assign s_axi_rvalid = s_q.rvalid;
  assign s_axi_rdata = s_q.rdata;
  assign s_axi_rresp = s_q.rresp;
endmodule

// ### test/ee_link_asserts.sv
`timescale 1ns/1ps
module ee_link_asserts #(
  parameter int NSEL = 2
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // link
  input wire logic sclk,
  input wire logic mosi,
  input wire logic [NSEL-1:0] cs_n,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic miso
);
  // ****************************************
  // helper counters
  // ****************************************
  logic [7:0] gap_q;
  logic [3:0] rise_q;
  logic [2:0] idle_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gap_q <= 8'h00;
      rise_q <= 4'h0;
      idle_q <= 3'h0;
    end else begin
      gap_q <= $changed(sclk) ? 8'h00 : gap_q + {7'h00, gap_q != 8'hff};
      rise_q <= cs_n[0] ? 4'h0 : rise_q + {3'h0, $rose(sclk)};
      idle_q <= !cs_n[0] ? 3'h0 : idle_q + {2'h0, idle_q != 3'h7};
    end
  end
  // ****************************************
  // link rules
  // ****************************************
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence mosi_hold_s;
    $stable(mosi) ##1 $stable(mosi);
  endsequence
  chk_one_select: assert property ($countones(~cs_n) <= 1)
    else $error("more than one select low");
  chk_byte_whole: assert property ($rose(cs_n[0]) |-> rise_q[2:0] == 3'h0)
    else $error("frame closed on a partial byte");
  chk_mosi_capture: assert property ($rose(sclk) |-> mosi_hold_s)
    else $error("mosi moved around the capture edge");
  // the fastest rate toggles every 8 cycles; a change within 6 means a runaway divider
  chk_sclk_spacing: assert property ($changed(sclk) && !(&cs_n) |-> gap_q >= 8'd6)
    else $error("serial clock edges too close");
  chk_out_release: assert property ($rose(cs_n[0]) |-> ##[0:3] !miso_oe)
    else $error("output not released after deselect");
  chk_out_idle: assert property (idle_q >= 3'h4 |-> !miso_oe)
    else $error("output driven while deselected");
  chk_out_start: assert property ($rose(miso_oe) |-> !cs_n[0])
    else $error("output driven without select");
  chk_miso_steady: assert property ($rose(sclk) && miso_oe |-> miso_o == $past(miso_o, 3))
    else $error("output bit moved before capture");
  // a released line must read as the pull-up level, or the master shifts in garbage
  chk_miso_pullup: assert property (!miso_oe |-> miso == 1'b1)
    else $error("released output line not high");
endmodule

// ### test/spi_serial_eeprom_protocol_tb.sv
`timescale 1ns/1ps
`include "ee_link_params.svh"
`define CHECK(got, exp) \
  begin \
    samples_checked++; \
    if ((got) !== (exp)) begin \
      err_count++; \
      $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
    end \
  end
module spi_serial_eeprom_protocol_tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_awready, s_axi_wvalid = 1'b0, s_axi_wready;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_bvalid, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, rate = 2'h0;
  logic [7:0] status_q;
  logic [31:0] d;
  logic mode = 1'b0;
  logic [7:0] rq[$], bq[$];
  int err_count = 0;
  int samples_checked = 0;
  always #4 aclk = ~aclk;
  ee_link_if #(.NSEL(2)) link_if_inst ();
  ee_host #(.NSEL(2)) ee_host_inst (.aclk(aclk), .aresetn(aresetn), .link(link_if_inst.host_mp),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));
  // write time kept long enough that a status read can still see it busy
  ee_device #(.SEL_INDEX(0), .WRITE_CYCLES(1000)) ee_device_inst (.aclk(aclk),
    .aresetn(aresetn), .link(link_if_inst.dev_mp), .status_q(status_q));
  ee_link_asserts #(.NSEL(2)) ee_link_asserts_inst (.aclk(aclk), .aresetn(aresetn),
    .sclk(link_if_inst.sclk), .mosi(link_if_inst.mosi), .cs_n(link_if_inst.cs_n),
    .miso_o(link_if_inst.miso_o), .miso_oe(link_if_inst.miso_oe), .miso(link_if_inst.miso));
  // ****************************************
  // bus tasks
  // ****************************************
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wstrb <= 4'h1;
    s_axi_bready <= 1'b1;
    fork
      begin
        do @(posedge aclk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
      end
      begin
        do @(posedge aclk); while (s_axi_wready !== 1'b1);
        s_axi_wvalid <= 1'b0;
      end
    join
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    // rvalid is launched at the edge that takes the address: look from the next edge
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    v = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // ****************************************
  // link tasks
  // ****************************************
  task automatic ctrl(input logic [1:0] dv, input logic on);
    logic [1:0] r;
    axi_wr(`REG_CTRL, {25'h0, dv, on, 1'b1, mode, rate}, r);
    repeat (8) @(posedge aclk);
  endtask
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    logic [31:0] v;
    logic [1:0] r;
    int n;
    axi_wr(`REG_DATA, {24'h0, tx}, r);
    n = 0;
    do begin
      axi_rd(`REG_STAT, v, r);
      n++;
    end while (v[`STAT_BUSY] !== 1'b0 && n < 1000);
    // a byte that never ends is a mismatch, not a silent pass
    if (v[`STAT_BUSY] !== 1'b0) begin
      err_count++;
      $display("unexpected at %0t: got %h expected %h", $time, v[`STAT_BUSY], 1'b0);
    end
    rx = v[15:8];
  endtask
  task automatic run(input logic [1:0] dv, input logic [7:0] q[$], output logic [7:0] o[$]);
    logic [7:0] rx;
    o = {};
    ctrl(dv, 1'b1);
    foreach (q[i]) begin
      xfer(q[i], rx);
      o.push_back(rx);
    end
    ctrl(dv, 1'b0);
  endtask
  task automatic sr(input logic [7:0] exp);
    run(2'd0, '{`CMD_STAT_RD, 8'h00}, rq);
    `CHECK(rq[1], exp);
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      run(2'd0, '{`CMD_STAT_RD, 8'h00}, rq);
      n++;
    end while (rq[1][`SR_BUSY] !== 1'b0 && n < 40);
    sr(8'h00);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [7:0] rx;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    axi_rd(8'h0c, d, resp);
    `CHECK(resp, `RESP_SLVERR);
    `CHECK(d, 32'h0);
    axi_wr(8'h0c, 32'h1, resp);
    `CHECK(resp, `RESP_SLVERR);
    // output still off after reset: no byte may start
    axi_wr(`REG_DATA, 32'h55, resp);
    axi_rd(`REG_STAT, d, resp);
    `CHECK(d, 32'h0);
    axi_rd(`REG_DATA, d, resp);
    `CHECK(d, 32'h0);
    for (int m = 0; m < 2; m++) begin
      mode = m[0];
      ctrl(2'd0, 1'b0);
      sr(8'h00);
      ctrl(2'd0, 1'b1);
      xfer(`CMD_SET_LATCH, rx);
      `CHECK(status_q, 8'h00);
      ctrl(2'd0, 1'b0);
      `CHECK(status_q, 8'h02);
      sr(8'h02);
      run(2'd0, '{`CMD_CLR_LATCH}, rq);
      sr(8'h00);
      run(2'd0, '{`CMD_STAT_WR, 8'hfc}, rq);
      sr(8'h00);
      run(2'd0, '{`CMD_SET_LATCH}, rq);
      run(2'd0, '{`CMD_STAT_WR, 8'hfc}, rq);
      sr(8'h0c);
      run(2'd0, '{`CMD_SET_LATCH}, rq);
      run(2'd0, '{8'h0a, 8'h10, 8'h77}, rq);
      run(2'd0, '{`CMD_STAT_RD, 8'h00}, rq);
      `CHECK(rq[1] & 8'hfd, 8'h0c);
      run(2'd0, '{`CMD_SET_LATCH}, rq);
      run(2'd0, '{`CMD_STAT_WR, 8'h00}, rq);
      sr(8'h00);
      run(2'd0, '{`CMD_SET_LATCH}, rq);
      run(2'd0, '{8'h0a, 8'h10, 8'h5a ^ m[7:0], 8'ha5}, rq);
      run(2'd0, '{`CMD_SET_LATCH}, rq);
      sr(8'h01);
      wait_idle();
      run(2'd0, '{`CMD_SET_LATCH}, rq);
      run(2'd0, '{8'h02, 8'h10, 8'h3c ^ m[7:0]}, rq);
      wait_idle();
      bq = '{8'h02, 8'h28};
      for (int i = 0; i < 16; i++) bq.push_back(i[7:0] + m[7:0]);
      run(2'd0, '{`CMD_SET_LATCH}, rq);
      run(2'd0, bq, rq);
      wait_idle();
      run(2'd0, '{8'h0b, 8'h10, 8'hd0, 8'h0f}, rq);
      `CHECK(rq[2], 8'h5a ^ m[7:0]);
      `CHECK(rq[3], 8'ha5);
      run(2'd0, '{8'h03, 8'h10, 8'hd0}, rq);
      `CHECK(rq[2], 8'h3c ^ m[7:0]);
      run(2'd0, '{8'h03, 8'h20, 8'hd0}, rq);
      `CHECK(rq[2], 8'h08 + m[7:0]);
    end
    run(2'd1, '{`CMD_SET_LATCH}, rq);
    sr(8'h00);
    run(2'd1, '{`CMD_STAT_RD, 8'h00}, rq);
    `CHECK(rq[1], 8'hff);
    for (int r = 0; r < 4; r++) begin
      rate = r[1:0];
      sr(8'h00);
      axi_rd(`REG_CTRL, d, resp);
      `CHECK(resp, `RESP_OKAY);
      `CHECK(d, {25'h0, 2'd0, 1'b0, 1'b1, mode, rate});
    end
    results();
  end
  initial begin
    repeat (100000) @(posedge aclk);
    err_count++;
    results();
  end
endmodule
